//--- logic/bmr_consts.vh
// Constants for the bank match, refresh and SDRAM init block
`ifndef BMR_CONSTS_VH
`define BMR_CONSTS_VH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define BMR_OFS_REFCTL      8'h00
`define BMR_OFS_STATUS      8'h04
`define BMR_OFS_CFG         8'h08
`define BMR_OFS_CMD         8'h0c
`define BMR_OFS_MATCH       8'h10
`define BMR_OFS_MRSVAL      8'h14

// ---------------------------------------------------------------
// Reset values and fields
// ---------------------------------------------------------------
`define BMR_REFCTL_RST      32'h0100_0100
`define BMR_RELOAD_MSB      31
`define BMR_RELOAD_LSB      16
`define BMR_RATE_MSB        15
`define BMR_RATE_LSB        0
`define BMR_REF_STATUS      8'h0c
`define BMR_PSEUDO_RST      16'h0100
`define BMR_RATE_RST        16'h0100

// Config register fields
`define BMR_CFG_SIZE_LSB    0
`define BMR_CFG_BS_LSB      5
`define BMR_CFG_AS_LSB      7
`define BMR_CFG_CT_LSB      10
`define BMR_CFG_LAT_LSB     14
`define BMR_CFG_BL_LSB      16
`define BMR_CFG_BANK_LSB    20

// Mode register value fields
`define BMR_MR_BL_LSB       0
`define BMR_MR_LAT_LSB      4

// Exception codes
`define BMR_EXC_DRAM3       2'h0
`define BMR_EXC_DRAM4       2'h1
`define BMR_EXC_RETRY       2'h2
`define BMR_EXC_SDRAM       2'h3

`endif

//--- logic/bmr_size_match.v
// Bank size compare for one configuration cache entry
`timescale 1ns/1ps
`default_nettype none

module bmr_size_match #(
    parameter AW = 32
) (
    input  wire [AW-1:0] addr_i,
    input  wire [AW-1:0] base_i,
    input  wire [4:0]    bank_size_code_i,
    input  wire          valid_i,
    output wire          hit_o
);
    wire [AW-1:0] mask;
    // Code n keeps top n bits; zero masks all bits out
    assign mask  = ~({AW{1'b1}} >> bank_size_code_i);
    assign hit_o = valid_i & (((addr_i ^ base_i) & mask) == {AW{1'b0}});
endmodule

`default_nettype wire

//--- logic/bmr_top.v
// Bank match, refresh controller and SDRAM init sequencing
`timescale 1ns/1ps
`default_nettype none
`include "bmr_consts.vh"

module bmr_top #(
    parameter ENTRIES = 6,
    parameter PWRUP_REFRESHES = 8
) (
    input  wire        clk_i,
    input  wire        rst_n_i,
    // AHB-Lite slave
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output wire [31:0] hrdata_o,
    output wire        hreadyout_o,
    output wire        hresp_o,
    // Memory side
    input  wire [31:0] access_addr_i,
    input  wire        access_req_i,
    input  wire [1:0]  except_code_i,
    output reg  [63:0] ad_out_o,
    output wire        ad_oe_n_o,
    output reg  [16:0] row_column_addr_bus_o,
    output reg  [4:0]  mem_state_o,
    output reg         cmd_mrs_o,
    output reg         cmd_dcab_o,
    output wire        entry_hit_o
);
    // -----------------------------------------------------------
    // States
    // -----------------------------------------------------------
    localparam [4:0] S_AD1 = 5'h00, S_AD2 = 5'h01, S_RL1 = 5'h02,
                     S_RL2 = 5'h03, S_AC1 = 5'h04, S_AC2 = 5'h05,
                     S_MRS = 5'h06, S_CBR = 5'h07, S_RF1 = 5'h08,
                     S_RF2 = 5'h09, S_RF3 = 5'h0a, S_RF4 = 5'h0b,
                     S_DCB = 5'h0c, S_COL = 5'h0d;

    // -----------------------------------------------------------
    // Registers
    // -----------------------------------------------------------
    reg [31:0] refresh_control_reg;
    reg [31:0] cfg_reg;
    reg [15:0] pseudo_reg;
    reg [15:0] rate_cnt_reg;
    reg        ref_pend_reg;
    reg        pwrup_reg;
    reg [7:0]  pwr_cnt_reg;
    reg        is_ref_reg;
    reg        mrs_pend_reg;
    reg [2:0]  mrs_bank_reg;
    reg [1:0]  exc_reg;
    reg [ENTRIES-1:0] valid_reg;
    reg [ENTRIES-1:0] mrs_done_reg;
    reg [31:0] base_reg [0:ENTRIES-1];
    reg [4:0]  size_reg [0:ENTRIES-1];
    reg        dp_act_reg;
    reg        dp_wr_reg;
    reg [7:0]  dp_addr_reg;
    reg [31:0] rdata_reg;
    reg [15:0] ref_done_cnt_reg;
    integer    i;

    // -----------------------------------------------------------
    // Bank match
    // -----------------------------------------------------------
    wire [ENTRIES-1:0] hit_vec;
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g = g + 1) begin : g_match
            bmr_size_match #(.AW(32)) u_match (
                .addr_i           (access_addr_i),
                .base_i           (base_reg[g]),
                .bank_size_code_i (size_reg[g]),
                .valid_i          (valid_reg[g]),
                .hit_o            (hit_vec[g])
            );
        end
    endgenerate
    assign entry_hit_o = |hit_vec;

    // -----------------------------------------------------------
    // Config fields
    // -----------------------------------------------------------
    wire [1:0] bus_width_code     = cfg_reg[`BMR_CFG_BS_LSB+1:`BMR_CFG_BS_LSB];
    wire [2:0] address_mux_select = cfg_reg[`BMR_CFG_AS_LSB+2:`BMR_CFG_AS_LSB];
    wire [3:0] cyc_timing  = cfg_reg[`BMR_CFG_CT_LSB+3:`BMR_CFG_CT_LSB];
    wire [1:0] cfg_lat     = cfg_reg[`BMR_CFG_LAT_LSB+1:`BMR_CFG_LAT_LSB];
    wire [2:0] cfg_bl      = cfg_reg[`BMR_CFG_BL_LSB+2:`BMR_CFG_BL_LSB];
    wire       is_sdram    = cyc_timing[3];

    // Latency code 3 stands for four; parts run at three
    wire [1:0] mr_lat = (cfg_lat == 2'h3) ? 2'h2 : cfg_lat;
    // Burst length and latency in the low twelve bits
    wire [11:0] mr_val = {5'h00, 1'b0, mr_lat, 1'b0, cfg_bl};
    // Logical address: shift up by bus width
    wire [15:0] mr_logical = {4'h0, mr_val} << bus_width_code;
    // Mux select moves the row field down the pins
    wire [16:0] mr_pins = {1'b0, mr_logical} >> address_mux_select;

    // -----------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // -----------------------------------------------------------
    wire take = hsel_i & htrans_i[1] & hready_i;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = rdata_reg;
    wire wr_now = dp_act_reg & dp_wr_reg;
    // Read data is captured with the address phase; a read right
    // behind a write to the same register sees the old value
    reg [31:0] rd_next;

    always @* begin
        case (haddr_i[7:0])
            `BMR_OFS_REFCTL: rd_next = refresh_control_reg;
            `BMR_OFS_STATUS: rd_next = {5'h00, is_ref_reg, pwrup_reg,
                                 mrs_pend_reg, 8'h00, pseudo_reg};
            `BMR_OFS_CFG:    rd_next = cfg_reg;
            `BMR_OFS_MATCH:  rd_next = {{(32-ENTRIES){1'b0}}, hit_vec};
            `BMR_OFS_MRSVAL: rd_next = {15'h0000, mr_pins};
            default:         rd_next = {16'h0000, ref_done_cnt_reg};
        endcase
    end

    // -----------------------------------------------------------
    // Refresh scheduling
    // -----------------------------------------------------------
    // Counts down to zero; a rate of n puts ticks n+1 cycles apart
    wire tick = (rate_cnt_reg == 16'h0000);
    wire in_ref_row = (mem_state_o == S_AD2) & is_ref_reg;

    // -----------------------------------------------------------
    // State machine
    // -----------------------------------------------------------
    reg [4:0] st_next;
    always @* begin
        case (mem_state_o)
            S_AD1: begin
                // Refresh first, then mode set, then page access
                if (ref_pend_reg | pwrup_reg | mrs_pend_reg |
                    access_req_i) begin
                    st_next = S_AD2;
                end else begin
                    st_next = S_AD1;
                end
            end
            S_AD2: begin
                if (is_ref_reg) begin
                    case (except_code_i)
                        `BMR_EXC_RETRY: st_next = S_AD1;
                        `BMR_EXC_SDRAM: st_next = S_RF1;
                        default:        st_next = S_CBR;
                    endcase
                end else if (mrs_pend_reg) begin
                    st_next = S_MRS;
                end else if (is_sdram) begin
                    st_next = S_AC1;
                end else begin
                    st_next = S_RL1;
                end
            end
            S_CBR:   st_next = S_RF1;
            S_RF1:   st_next = S_RF2;
            S_RF2:   st_next = S_RF3;
            S_RF3: begin
                if (exc_reg == `BMR_EXC_DRAM4) begin
                    st_next = S_RF4;
                end else if (exc_reg == `BMR_EXC_SDRAM && pwrup_reg) begin
                    st_next = S_DCB;
                end else begin
                    st_next = S_AD1;
                end
            end
            S_RF4:   st_next = S_AD1;
            S_DCB:   st_next = S_AD1;
            S_MRS:   st_next = S_AD1;
            S_RL1:   st_next = S_RL2;
            S_RL2:   st_next = S_COL;
            S_AC1:   st_next = S_AC2;
            S_AC2:   st_next = S_COL;
            S_COL:   st_next = S_AD1;
            default: st_next = S_AD1;
        endcase
    end

    wire ref_end = (mem_state_o == S_RF3 && exc_reg != `BMR_EXC_DRAM4) |
                   (mem_state_o == S_RF4);

    // -----------------------------------------------------------
    // Sequential logic
    // -----------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            refresh_control_reg <= `BMR_REFCTL_RST;
            cfg_reg          <= 32'h0000_0000;
            pseudo_reg       <= `BMR_PSEUDO_RST;
            rate_cnt_reg     <= `BMR_RATE_RST;
            ref_pend_reg     <= 1'b0;
            pwrup_reg        <= 1'b1;
            pwr_cnt_reg      <= 8'h00;
            is_ref_reg       <= 1'b0;
            mrs_pend_reg     <= 1'b0;
            mrs_bank_reg     <= 3'h0;
            exc_reg          <= 2'h0;
            valid_reg        <= {ENTRIES{1'b0}};
            mrs_done_reg     <= {ENTRIES{1'b0}};
            dp_act_reg       <= 1'b0;
            dp_wr_reg        <= 1'b0;
            dp_addr_reg      <= 8'h00;
            rdata_reg        <= 32'h0000_0000;
            ref_done_cnt_reg <= 16'h0000;
            mem_state_o      <= S_AD1;
            cmd_mrs_o        <= 1'b0;
            cmd_dcab_o       <= 1'b0;
            ad_out_o         <= 64'h0;
            row_column_addr_bus_o <= 17'h00000;
            for (i = 0; i < ENTRIES; i = i + 1) begin
                base_reg[i] <= 32'h0000_0000;
                size_reg[i] <= 5'h00;
            end
        end else begin
            dp_act_reg  <= take;
            dp_wr_reg   <= hwrite_i;
            dp_addr_reg <= haddr_i[7:0];
            if (take && !hwrite_i) begin
                rdata_reg <= rd_next;
            end
            mem_state_o <= st_next;
            cmd_mrs_o   <= (st_next == S_MRS);
            cmd_dcab_o  <= (st_next == S_DCB);

            // Rate counter reloads from the low half
            if (tick) begin
                rate_cnt_reg <= refresh_control_reg[`BMR_RATE_MSB:`BMR_RATE_LSB];
            end else begin
                rate_cnt_reg <= rate_cnt_reg - 16'h0001;
            end
            // Tick wins over the clear taken in AD1 in the same cycle
            // Outside power-up a retried refresh waits for the next tick
            if (tick) begin
                ref_pend_reg <= 1'b1;
            end else if (mem_state_o == S_AD1 && ref_pend_reg) begin
                ref_pend_reg <= 1'b0;
            end

            if (mem_state_o == S_AD1) begin
                is_ref_reg <= ref_pend_reg | pwrup_reg;
            end
            if (mem_state_o == S_AD2) begin
                exc_reg <= except_code_i;
            end

            // Status code and pseudo-address on the bus
            if (st_next == S_AD2 && mem_state_o == S_AD1 &&
                (ref_pend_reg | pwrup_reg)) begin
                ad_out_o <= {24'h000000, `BMR_REF_STATUS, 15'h0000,
                             pseudo_reg, 1'b0};
            end else if (st_next == S_MRS) begin
                row_column_addr_bus_o <= mr_pins;
            end

            // Retry leaves the pseudo-address alone
            if (ref_end) begin
                ref_done_cnt_reg <= ref_done_cnt_reg + 16'h0001;
                if (pseudo_reg == 16'h0001 || pseudo_reg == 16'h0000) begin
                    pseudo_reg <= refresh_control_reg[`BMR_RELOAD_MSB:`BMR_RELOAD_LSB];
                end else begin
                    pseudo_reg <= pseudo_reg - 16'h0001;
                end
                if (pwrup_reg) begin
                    pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
                    // Compared at 32 bits so the parameter is not cut
                    if ({24'h000000, pwr_cnt_reg} == PWRUP_REFRESHES - 1) begin
                        pwrup_reg <= 1'b0;
                    end
                end
            end

            // One pending slot: load SDRAM banks one at a time
            if (st_next == S_MRS) begin
                mrs_pend_reg <= 1'b0;
                mrs_done_reg[mrs_bank_reg] <= 1'b1;
            end

            if (wr_now) begin
                case (dp_addr_reg)
                    `BMR_OFS_REFCTL: refresh_control_reg <= hwdata_i;
                    `BMR_OFS_CFG: begin
                        cfg_reg <= hwdata_i;
                    end
                    `BMR_OFS_CMD: begin
                        // Bit 0 loads entry, bit 1 flushes it
                        if (hwdata_i[0]) begin
                            valid_reg[cfg_reg[22:20]] <= 1'b1;
                            base_reg[cfg_reg[22:20]] <= access_addr_i;
                            size_reg[cfg_reg[22:20]] <= cfg_reg[4:0];
                            if (is_sdram && !mrs_done_reg[cfg_reg[22:20]]) begin
                                mrs_pend_reg <= 1'b1;
                                mrs_bank_reg <= cfg_reg[22:20];
                            end
                        end
                        if (hwdata_i[1]) begin
                            valid_reg[cfg_reg[22:20]]    <= 1'b0;
                            mrs_done_reg[cfg_reg[22:20]] <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Bus tri-states except during row time of a refresh
    // ad_out_o keeps its last value; only the enable marks it valid
    assign ad_oe_n_o = ~in_ref_row;
endmodule

`default_nettype wire

//--- verif/bmr_mem_model.sv
// Memory bank model answering refresh cycles with an exception code
`timescale 1ns/1ps
`default_nettype none

module bmr_mem_model (
    input  wire logic       ad_oe_n_i,
    input  wire logic [1:0] refresh_kind_i,
    output logic      [1:0] except_code_o
);
    // ----------------------------------------------------------------
    // Exception code
    // ----------------------------------------------------------------
    // Only valid while the bus is driven; inverse elsewhere, no free 0s
    assign except_code_o = ad_oe_n_i ? ~refresh_kind_i
                                     : refresh_kind_i;
endmodule

`default_nettype wire

//--- verif/bmr_checker_properties.sv
// Concurrent checks on refresh and SDRAM command sequencing
`timescale 1ns/1ps
`default_nettype none

module bmr_checker (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [1:0]  except_code_i,
    input wire logic [63:0] ad_out_o,
    input wire logic        ad_oe_n_o,
    input wire logic [4:0]  mem_state_o,
    input wire logic        cmd_mrs_o,
    input wire logic        cmd_dcab_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------------------------------
    // Refresh row time
    // ----------------------------------------------------------------
    chk_status_code:
        assert property (!ad_oe_n_o |-> ad_out_o[39:32] == 8'h0c)
        else $error("Refresh status code wrong");
    chk_bus_in_ad2:
        assert property (!ad_oe_n_o |-> mem_state_o == 5'h01)
        else $error("Bus driven outside AD2");
    chk_retry_ends:
        assert property (!ad_oe_n_o && except_code_i == 2'h2
            |=> mem_state_o == 5'h00)
        else $error("Retried refresh not ended");
    chk_dram_three:
        assert property (!ad_oe_n_o && except_code_i == 2'h0
            |=> mem_state_o == 5'h07 ##1 mem_state_o == 5'h08
            ##1 mem_state_o == 5'h09 ##1 mem_state_o == 5'h0a
            ##1 mem_state_o == 5'h00)
        else $error("DRAM refresh sequence wrong");
    chk_dram_slow:
        assert property (!ad_oe_n_o && except_code_i == 2'h1
            |=> mem_state_o == 5'h07 ##1 mem_state_o == 5'h08
            ##1 mem_state_o == 5'h09 ##1 mem_state_o == 5'h0a
            ##1 mem_state_o == 5'h0b ##1 mem_state_o == 5'h00)
        else $error("Slow refresh sequence wrong");
    chk_sdram_refresh:
        assert property (!ad_oe_n_o && except_code_i == 2'h3
            |=> mem_state_o == 5'h08 ##1 mem_state_o == 5'h09
            ##1 mem_state_o == 5'h0a
            ##1 (mem_state_o == 5'h0c || mem_state_o == 5'h00))
        else $error("SDRAM refresh sequence wrong");

    // ----------------------------------------------------------------
    // SDRAM commands
    // ----------------------------------------------------------------
    chk_mrs_state:
        assert property (cmd_mrs_o == (mem_state_o == 5'h06))
        else $error("Mode set flag out of step");
    chk_mrs_after_ad2:
        assert property (cmd_mrs_o |-> $past(mem_state_o) == 5'h01)
        else $error("Mode set not entered from AD2");
    chk_dcab_after_rf3:
        assert property (cmd_dcab_o |-> mem_state_o == 5'h0c
            && $past(mem_state_o) == 5'h0a)
        else $error("Deactivate not after refresh");
endmodule

bind bmr_top bmr_checker u_chk (
    .clk_i, .rst_n_i, .except_code_i, .ad_out_o,
    .ad_oe_n_o, .mem_state_o, .cmd_mrs_o, .cmd_dcab_o
);

`default_nettype wire

//--- verif/bank_match_refresh_sdram_init_bench.sv
// Self-checking bench for bank match, refresh and SDRAM init
`timescale 1ns/1ps
`default_nettype none
`include "bmr_consts.vh"

`define CHK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("FAIL %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module bank_match_refresh_sdram_init_bench;
    localparam logic [31:0] a_ref = {24'h0, `BMR_OFS_REFCTL};
    localparam logic [31:0] a_cfg = {24'h0, `BMR_OFS_CFG};
    localparam logic [31:0] a_cmd = {24'h0, `BMR_OFS_CMD};
    logic        clk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, access_addr_i, rd;
    logic [1:0]  htrans_i, except_code_i, refresh_kind;
    logic [2:0]  hsize_i;
    logic [63:0] ad_out_o;
    logic        ad_oe_n_o, cmd_mrs_o, cmd_dcab_o, entry_hit_o, access_req_i;
    logic [16:0] row_column_addr_bus_o;
    logic [4:0]  mem_state_o;
    logic [15:0] pa, pb;
    int          errors, tests_run, n;

    bmr_top #(.PWRUP_REFRESHES(2)) dut (
        .clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
        .hreadyout_o, .hresp_o, .access_addr_i, .access_req_i,
        .except_code_i, .ad_out_o, .ad_oe_n_o, .row_column_addr_bus_o,
        .mem_state_o, .cmd_mrs_o, .cmd_dcab_o, .entry_hit_o
    );
    bmr_mem_model mem (.ad_oe_n_i(ad_oe_n_o), .refresh_kind_i(refresh_kind),
                       .except_code_o(except_code_i));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Single AHB word transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        hsize_i <= 3'h2;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask

    // Pseudo-address of the next refresh, taken in AD2
    task automatic next_ref(output logic [15:0] p);
        while (ad_oe_n_o !== 1'b1) @(posedge clk_i);
        while (ad_oe_n_o !== 1'b0) @(posedge clk_i);
        p = ad_out_o[16:1];
    endtask

    function automatic logic [15:0] dec(input logic [15:0] p);
        return (p <= 16'h0001) ? 16'h0003 : p - 16'h0001;
    endfunction

    task automatic probe(input logic [31:0] a, input logic e);
        access_addr_i <= a;
        @(posedge clk_i);
        `CHK("entry hit", e, entry_hit_o);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_powerup();
        for (n = 0; n < 4000 && cmd_dcab_o !== 1'b1; n++) @(posedge clk_i);
        `CHK("deactivate at power-up", 1'b1, cmd_dcab_o);
        refresh_kind <= 2'h0;
    endtask

    task automatic t_regs();
        bus(1'b0, a_ref, 32'h0, rd);
        `CHK("refctl reset", 32'h0100_0100, rd);
        `CHK("bus response", 1'b0, hresp_o);
        bus(1'b1, 32'h0000_0040, 32'hffff_ffff, rd);
        bus(1'b0, a_ref, 32'h0, rd);
        `CHK("refctl after unmapped", 32'h0100_0100, rd);
        bus(1'b1, a_ref, 32'h0003_0010, rd);
        bus(1'b0, a_ref, 32'h0, rd);
        `CHK("refctl written", 32'h0003_0010, rd);
    endtask

    // Long enough to leave the reset reload and wrap several times
    task automatic t_countdown();
        next_ref(pa);
        for (int i = 0; i < 270; i++) begin
            next_ref(pb);
            `CHK("pseudo step", dec(pa), pb);
            pa = pb;
        end
    endtask

    task automatic t_kinds();
        next_ref(pa);
        refresh_kind <= 2'h2;
        next_ref(pb);
        `CHK("pseudo before retry", dec(pa), pb);
        refresh_kind <= 2'h1;
        next_ref(pa);
        `CHK("pseudo kept on retry", pb, pa);
        refresh_kind <= 2'h0;
        for (n = 0; n < 10 && mem_state_o !== 5'h0b; n++) @(posedge clk_i);
        `CHK("slow refresh state", 5'h0b, mem_state_o);
        next_ref(pb);
        `CHK("pseudo after slow", dec(pa), pb);
    endtask

    task automatic t_mrs();
        logic [31:0] ev;
        for (int i = 0; i < 4; i++) begin
            ev = {26'h0, (i == 3) ? 2'h2 : 2'(i), 1'b0, 3'(i + 1)};
            ev = (ev << i) >> (3 - i);
            bus(1'b1, a_cfg, (i << 5) | ((3 - i) << 7) | 32'h0000_2000
                | (i << 14) | ((i + 1) << 16) | (i << 20), rd);
            bus(1'b1, a_cmd, 32'h0000_0001, rd);
            for (n = 0; n < 500 && cmd_mrs_o !== 1'b1; n++) @(posedge clk_i);
            `CHK("mode pins", ev[16:0], row_column_addr_bus_o);
            while (cmd_mrs_o === 1'b1) @(posedge clk_i);
            bus(1'b1, a_cmd, 32'h0000_0001, rd);
            for (n = 0; n < 40 && cmd_mrs_o !== 1'b1; n++) @(posedge clk_i);
            `CHK("no second mode set", 1'b0, cmd_mrs_o);
        end
    endtask

    task automatic t_match();
        logic [4:0] k;
        logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h08, 5'h10, 5'h1f};
        for (int j = 0; j < 4; j++) begin
            bus(1'b1, a_cfg, j << 20, rd);
            bus(1'b1, a_cmd, 32'h0000_0002, rd);
        end
        for (int i = 0; i < 5; i++) begin
            k = codes[i];
            access_addr_i <= 32'ha5a5_5a5a;
            bus(1'b1, a_cfg, {27'h0, k}, rd);
            bus(1'b1, a_cmd, 32'h0000_0001, rd);
            probe(32'ha5a5_5a5a, 1'b1);
            probe(32'ha5a5_5a5a ^ (32'h1 << (31 - k)), 1'b1);
            if (k != 5'h00) probe(32'ha5a5_5a5a ^ (32'h1 << (32 - k)), 1'b0);
        end
    endtask

    // Page access row states, DRAM timing then SDRAM timing
    task automatic t_page();
        logic [4:0] s1;
        for (int m = 0; m < 2; m++) begin
            s1 = (m == 1) ? 5'h04 : 5'h02;
            bus(1'b1, a_cfg, (m == 1) ? 32'h0000_2000 : 32'h0, rd);
            access_req_i <= 1'b1;
            for (n = 0; n < 60 && mem_state_o !== s1; n++) @(posedge clk_i);
            access_req_i <= 1'b0;
            `CHK("first row state", s1, mem_state_o);
            @(posedge clk_i);
            `CHK("second row state", s1 + 5'h01, mem_state_o);
            while (mem_state_o !== 5'h00) @(posedge clk_i);
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        {rst_n_i, hsel_i, hwrite_i, haddr_i, hwdata_i} = '0;
        {htrans_i, hsize_i, access_addr_i, access_req_i} = '0;
        refresh_kind = 2'h3;
        errors = 0;
        tests_run = 0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_powerup();
        t_regs();
        t_countdown();
        t_kinds();
        t_mrs();
        t_match();
        t_page();
        wrap_up();
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        wrap_up();
    end
endmodule

`default_nettype wire
